// *** swc_pkg.sv ***
// shared constants, timing counts and state types for the single-wire link
package swc_pkg;
    // ==========================================================
    // clock
    localparam int CLK_MHZ = 50;

    // ==========================================================
    // line timing in ns (std = standard speed, od = overdrive)
    localparam int T_STD_W1L_NS = 6000;
    localparam int T_STD_W0L_NS = 60000;
    localparam int T_STD_MSR_NS = 13000;
    localparam int T_STD_SLOT_NS = 65000;
    localparam int T_STD_REC_NS = 5000;
    localparam int T_STD_DSMP_NS = 30000;
    localparam int T_STD_FILT_NS = 1000;
    localparam int T_STD_REH_NS = 2000;
    localparam int T_OD_W1L_NS = 1000;
    localparam int T_OD_W0L_NS = 7500;
    localparam int T_OD_MSR_NS = 2000;
    localparam int T_OD_SLOT_NS = 8000;
    localparam int T_OD_REC_NS = 2000;
    localparam int T_OD_DSMP_NS = 3000;
    localparam int T_OD_REH_NS = 500;
    localparam int T_HYS_NS = 60;
    localparam int T_RST_LOW_NS = 480000;
    localparam int T_RST_WAIT_NS = 480000;
    localparam int T_RST_DET_NS = 240000;
    localparam int T_SPU_NS = 1000000;

    // ==========================================================
    // cycle counts: least times round up, longest times round down
    localparam int STD_W1L_CYC = T_STD_W1L_NS * CLK_MHZ / 1000;
    localparam int STD_W0L_CYC = (T_STD_W0L_NS * CLK_MHZ + 999) / 1000;
    localparam int STD_MSR_CYC = T_STD_MSR_NS * CLK_MHZ / 1000;
    localparam int STD_SLOT_CYC = (T_STD_SLOT_NS * CLK_MHZ + 999) / 1000;
    localparam int STD_REC_CYC = (T_STD_REC_NS * CLK_MHZ + 999) / 1000;
    localparam int STD_DSMP_CYC = T_STD_DSMP_NS * CLK_MHZ / 1000;
    localparam int STD_FILT_CYC = (T_STD_FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int STD_REH_CYC = (T_STD_REH_NS * CLK_MHZ + 999) / 1000;
    localparam int OD_W1L_CYC = T_OD_W1L_NS * CLK_MHZ / 1000;
    localparam int OD_W0L_CYC = (T_OD_W0L_NS * CLK_MHZ + 999) / 1000;
    localparam int OD_MSR_CYC = T_OD_MSR_NS * CLK_MHZ / 1000;
    localparam int OD_SLOT_CYC = (T_OD_SLOT_NS * CLK_MHZ + 999) / 1000;
    localparam int OD_REC_CYC = (T_OD_REC_NS * CLK_MHZ + 999) / 1000;
    localparam int OD_DSMP_CYC = T_OD_DSMP_NS * CLK_MHZ / 1000;
    localparam int OD_REH_CYC = (T_OD_REH_NS * CLK_MHZ + 999) / 1000;
    localparam int HYS_CYC = (T_HYS_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_LOW_CYC = (T_RST_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_WAIT_CYC = (T_RST_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_DET_CYC = (T_RST_DET_NS * CLK_MHZ + 999) / 1000;
    localparam int SPU_CYC = (T_SPU_NS * CLK_MHZ + 999) / 1000;

    // ==========================================================
    // command bytes
    localparam logic [7:0] CMD_SKIP = 8'hCC;
    localparam logic [7:0] CMD_COND_READ = 8'h0F;
    localparam logic [7:0] CMD_CHAIN = 8'h99;
    localparam logic [7:0] CTL_ON = 8'h5A;
    localparam logic [7:0] CTL_OFF = 8'h3C;
    localparam logic [7:0] CTL_DONE = 8'h96;
    localparam int ID_BITS = 64;

    // host operation codes
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;

    // ==========================================================
    // state types
    typedef enum logic [2:0] {
        BS_ROM = 3'h0,
        BS_FUNC = 3'h1,
        BS_CTL = 3'h2,
        BS_INV = 3'h3,
        BS_TX = 3'h4,
        BS_IGN = 3'h5
    } swc_byte_t;

    typedef enum logic [1:0] {
        CH_OFF = 2'h0,
        CH_ON = 2'h1,
        CH_DONE = 2'h2
    } swc_chain_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'h0,
        HS_SLOT = 3'h1,
        HS_RST_LOW = 3'h2,
        HS_RST_WAIT = 3'h3,
        HS_SPU = 3'h4
    } swc_host_t;
endpackage : swc_pkg

// *** swc_if.sv ***
// single-wire open-drain link between the bus controller and one device
`timescale 1ns/1ps
interface swc_if;
    logic dq_dev_oe;
    logic dq_host_oe;
    logic spu;
    logic dq;
    // bench-driven noise dip, seen as a third pulldown
    logic noise_low;

    // wired-AND of the open-drain pulldowns
    assign dq = ~(dq_dev_oe | dq_host_oe | noise_low);

    modport dev (input dq, output dq_dev_oe);
    modport host (input dq, output dq_host_oe, output spu);
endinterface : swc_if

// *** swc_fe.sv ***
// device line front end: synchroniser, glitch filter and rise hold-off
`timescale 1ns/1ps
module swc_fe (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic line_raw,
    input wire logic overdrive,
    output logic fall,
    output logic level
);
    // ==========================================================
    // state
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic lvl;
        logic fall;
        logic [7:0] lowcnt;
        logic [7:0] hold;
    } swc_fe_st_t;

    localparam logic [7:0] NEED_OD = 8'(swc_pkg::HYS_CYC);
    localparam logic [7:0] NEED_STD =
        8'(swc_pkg::HYS_CYC + swc_pkg::STD_FILT_CYC);

    swc_fe_st_t r_reg;
    swc_fe_st_t r_next;
    logic [7:0] need;

    if (swc_pkg::HYS_CYC + swc_pkg::STD_FILT_CYC > 255 ||
        swc_pkg::STD_REH_CYC > 255) begin : g_bad
        $error("swc_fe: filter counts exceed 8 bits");
    end

    // ==========================================================
    // filter
    always_comb begin
        r_next = r_reg;
        r_next.sync1 = line_raw;
        r_next.sync2 = r_reg.sync1;
        r_next.fall = 1'b0;
        need = overdrive ? NEED_OD : NEED_STD;
        if (r_reg.hold != 8'h00) begin
            r_next.hold = r_reg.hold - 8'h01;
        end
        if (r_reg.lvl) begin
            // shallow or held-off dips reset the low count
            if (r_reg.sync2 || r_reg.hold != 8'h00) begin
                r_next.lowcnt = 8'h00;
            end else if (r_reg.lowcnt + 8'h01 >= need) begin
                r_next.lvl = 1'b0;
                r_next.fall = 1'b1;
                r_next.lowcnt = 8'h00;
            end else begin
                r_next.lowcnt = r_reg.lowcnt + 8'h01;
            end
        end else if (r_reg.sync2) begin
            r_next.lvl = 1'b1;
            r_next.hold = overdrive ? 8'(swc_pkg::OD_REH_CYC)
                                    : 8'(swc_pkg::STD_REH_CYC);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '{sync1: 1'b1, sync2: 1'b1, lvl: 1'b1, fall: 1'b0,
                       lowcnt: 8'h00, hold: 8'h00};
        end else begin
            r_reg <= r_next;
        end
    end

    assign fall = r_reg.fall;
    assign level = r_reg.lvl;
endmodule : swc_fe

// *** swc_dev.sv ***
// device end: slot timing, chain commands and conditional identity read
`timescale 1ns/1ps
module swc_dev #(
    parameter logic [63:0] ROM_ID = 64'h0123456789ABCDEF,
    parameter int RST_DET_CYC = swc_pkg::RST_DET_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    swc_if.dev link,
    input wire logic overdrive,
    input wire logic chain_en_n_pin,
    input wire logic gpio_drive_low,
    output logic chain_done_oe,
    output logic chain_en_level,
    output logic [1:0] chain_state
);
    // ROM_ID is an arbitrary identity value

    if (RST_DET_CYC < 1 || RST_DET_CYC > 65535) begin : g_bad
        $error("swc_dev: RST_DET_CYC out of range");
    end

    // a shorter reset detect would reframe bytes inside a write-zero low;
    // at standard speed it must clear that speed's longer low as well; the check below compares only with OD_W0L_CYC
    if (RST_DET_CYC <= swc_pkg::OD_W0L_CYC) begin : g_short
        $error("swc_dev: RST_DET_CYC inside a write-zero low");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic drive;
        logic done_oe;
        logic active;
        swc_pkg::swc_byte_t byte_st;
        swc_pkg::swc_chain_t chain;
        logic [15:0] tmr;
        logic [15:0] lowtmr;
        logic [2:0] bit_cnt;
        logic [7:0] sh;
        logic [7:0] ctl;
        logic [5:0] rom_idx;
    } swc_dev_st_t;

    swc_dev_st_t r_reg;
    swc_dev_st_t r_next;
    logic fall;
    logic level;
    logic [15:0] smp_cyc;
    logic [7:0] byte_in;
    logic rom_bit;

    swc_fe u_fe (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .line_raw(link.dq),
        .overdrive(overdrive),
        .fall(fall),
        .level(level)
    );

    // ==========================================================
    // slot engine and command decode
    always_comb begin
        r_next = r_reg;
        r_next.en_s1 = chain_en_n_pin;
        r_next.en_s2 = r_reg.en_s1;
        smp_cyc = overdrive ? 16'(swc_pkg::OD_DSMP_CYC)
                            : 16'(swc_pkg::STD_DSMP_CYC);
        byte_in = {level, r_reg.sh[7:1]};
        rom_bit = ROM_ID[r_reg.rom_idx];

        // long low: bus reset, restart byte framing
        if (!level) begin
            if (r_reg.lowtmr != 16'(RST_DET_CYC)) begin
                r_next.lowtmr = r_reg.lowtmr + 16'h0001;
            end
        end else begin
            r_next.lowtmr = 16'h0000;
        end

        if (fall) begin
            r_next.active = 1'b1;
            r_next.tmr = 16'h0000;
            // a one reply leaves the line alone
            if (r_reg.byte_st == swc_pkg::BS_TX && !rom_bit) begin
                r_next.drive = 1'b1;
            end
        end else if (r_reg.active) begin
            r_next.tmr = r_reg.tmr + 16'h0001;
            if (r_reg.tmr == smp_cyc) begin
                // the slot ends here; the rest of it is recovery
                r_next.active = 1'b0;
                r_next.drive = 1'b0;
                r_next.sh = byte_in;
                r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
                if (r_reg.byte_st == swc_pkg::BS_TX) begin
                    r_next.rom_idx = r_reg.rom_idx + 6'h01;
                    // selected device now takes a function command
                    if (r_reg.rom_idx == 6'(swc_pkg::ID_BITS - 1)) begin
                        r_next.byte_st = swc_pkg::BS_FUNC;
                        r_next.bit_cnt = 3'h0;
                    end
                end else if (r_reg.bit_cnt == 3'h7) begin
                    unique case (r_reg.byte_st)
                        swc_pkg::BS_ROM: begin
                            if (byte_in == swc_pkg::CMD_SKIP) begin
                                r_next.byte_st = swc_pkg::BS_FUNC;
                            end else if (byte_in == swc_pkg::CMD_COND_READ
                                && r_reg.chain == swc_pkg::CH_ON
                                && !r_reg.en_s2) begin
                                r_next.byte_st = swc_pkg::BS_TX;
                                r_next.rom_idx = 6'h00;
                            end else begin
                                r_next.byte_st = swc_pkg::BS_IGN;
                            end
                        end
                        swc_pkg::BS_FUNC: begin
                            r_next.byte_st = (byte_in == swc_pkg::CMD_CHAIN)
                                ? swc_pkg::BS_CTL : swc_pkg::BS_IGN;
                        end
                        swc_pkg::BS_CTL: begin
                            r_next.ctl = byte_in;
                            r_next.byte_st = swc_pkg::BS_INV;
                        end
                        swc_pkg::BS_INV: begin
                            r_next.byte_st = swc_pkg::BS_IGN;
                            // control byte only counts if its inverse matches
                            if (byte_in == ~r_reg.ctl) begin
                                if (r_reg.ctl == swc_pkg::CTL_ON) begin
                                    r_next.chain = swc_pkg::CH_ON;
                                end else if (r_reg.ctl ==
                                    swc_pkg::CTL_OFF) begin
                                    r_next.chain = swc_pkg::CH_OFF;
                                end else if (r_reg.ctl == swc_pkg::CTL_DONE
                                    && r_reg.chain == swc_pkg::CH_ON) begin
                                    r_next.chain = swc_pkg::CH_DONE;
                                end
                            end
                        end
                        swc_pkg::BS_TX, swc_pkg::BS_IGN: begin
                            r_next.byte_st = r_reg.byte_st;
                        end
                    endcase
                end
            end
        end else begin
            // outside a slot the line is never pulled
            r_next.drive = 1'b0;
        end

        // a long low is a bus reset: byte framing restarts
        if (!level && r_reg.lowtmr == 16'(RST_DET_CYC - 1)) begin
            r_next.byte_st = swc_pkg::BS_ROM;
            r_next.bit_cnt = 3'h0;
            r_next.active = 1'b0;
            r_next.drive = 1'b0;
        end

        // done pin pulls low in chain done; user owns it when chain off
        r_next.done_oe = (r_next.chain == swc_pkg::CH_DONE) ||
            (r_next.chain == swc_pkg::CH_OFF && gpio_drive_low);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '{en_s1: 1'b1, en_s2: 1'b1, drive: 1'b0,
                       done_oe: 1'b0, active: 1'b0,
                       byte_st: swc_pkg::BS_IGN, chain: swc_pkg::CH_OFF,
                       tmr: 16'h0000, lowtmr: 16'h0000, bit_cnt: 3'h0,
                       sh: 8'h00, ctl: 8'h00, rom_idx: 6'h00};
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.dq_dev_oe = r_reg.drive;
    assign chain_done_oe = r_reg.done_oe;
    assign chain_en_level = r_reg.en_s2;
    assign chain_state = r_reg.chain;
endmodule : swc_dev

// *** swc_host.sv ***
// bus controller end: reset pulse, byte write and byte read slots
`timescale 1ns/1ps
module swc_host #(
    parameter int RST_LOW_CYC = swc_pkg::RST_LOW_CYC,
    parameter int RST_WAIT_CYC = swc_pkg::RST_WAIT_CYC,
    parameter int SPU_CYC = swc_pkg::SPU_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    swc_if.host link,
    input wire logic overdrive,
    input wire logic op_valid,
    input wire logic [1:0] op_code,
    input wire logic [7:0] wr_byte,
    input wire logic spu_after,
    output logic op_ready,
    output logic op_done,
    output logic [7:0] rd_byte
);
    if (RST_LOW_CYC < 1 || RST_LOW_CYC > 65535 || RST_WAIT_CYC < 1 ||
        RST_WAIT_CYC > 65535 || SPU_CYC < 1 || SPU_CYC > 65535)
    begin : g_bad
        $error("swc_host: count parameter out of range");
    end

    // ==========================================================
    // state
    typedef struct packed {
        swc_pkg::swc_host_t st;
        logic dq_s1;
        logic dq_s2;
        logic oe;
        logic spu;
        logic ready;
        logic done;
        logic od;
        logic spu_req;
        logic [1:0] op;
        logic [15:0] tmr;
        logic [2:0] bit_cnt;
        logic [7:0] sh;
        logic [7:0] rd;
    } swc_host_st_t;

    swc_host_st_t r_reg;
    swc_host_st_t r_next;
    logic [15:0] low_end;
    logic [15:0] smp_at;
    logic [15:0] slot_end;

    // ==========================================================
    // sequencer
    always_comb begin
        r_next = r_reg;
        r_next.dq_s1 = link.dq;
        r_next.dq_s2 = r_reg.dq_s1;
        r_next.done = 1'b0;
        smp_at = r_reg.od ? 16'(swc_pkg::OD_MSR_CYC)
                          : 16'(swc_pkg::STD_MSR_CYC);
        slot_end = r_reg.od
            ? 16'(swc_pkg::OD_SLOT_CYC + swc_pkg::OD_REC_CYC)
            : 16'(swc_pkg::STD_SLOT_CYC + swc_pkg::STD_REC_CYC);
        if (r_reg.op == swc_pkg::OP_WRITE && !r_reg.sh[0]) begin
            low_end = r_reg.od ? 16'(swc_pkg::OD_W0L_CYC)
                               : 16'(swc_pkg::STD_W0L_CYC);
        end else begin
            low_end = r_reg.od ? 16'(swc_pkg::OD_W1L_CYC)
                               : 16'(swc_pkg::STD_W1L_CYC);
        end
        unique case (r_reg.st)
            swc_pkg::HS_IDLE: begin
                if (op_valid) begin
                    r_next.ready = 1'b0;
                    r_next.op = op_code;
                    r_next.od = overdrive;
                    r_next.sh = wr_byte;
                    r_next.spu_req = spu_after;
                    r_next.bit_cnt = 3'h0;
                    r_next.tmr = 16'h0000;
                    r_next.oe = 1'b1;
                    r_next.st = (op_code == swc_pkg::OP_RESET)
                        ? swc_pkg::HS_RST_LOW : swc_pkg::HS_SLOT;
                end
            end
            swc_pkg::HS_SLOT: begin
                r_next.tmr = r_reg.tmr + 16'h0001;
                if (r_reg.tmr == low_end) begin
                    r_next.oe = 1'b0;
                end
                if (r_reg.op == swc_pkg::OP_READ && r_reg.tmr == smp_at) begin
                    r_next.sh = {r_reg.dq_s2, r_reg.sh[7:1]};
                end
                // slot plus recovery must expire before the next fall
                if (r_reg.tmr == slot_end) begin
                    r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
                    if (r_reg.op == swc_pkg::OP_WRITE) begin
                        r_next.sh = {1'b0, r_reg.sh[7:1]};
                    end
                    r_next.tmr = 16'h0000;
                    if (r_reg.bit_cnt != 3'h7) begin
                        r_next.oe = 1'b1;
                    end else if (r_reg.op == swc_pkg::OP_WRITE
                        && r_reg.spu_req) begin
                        r_next.spu = 1'b1;
                        r_next.st = swc_pkg::HS_SPU;
                    end else begin
                        // an absent reply reads as FFh: chain exhausted
                        r_next.rd = (r_reg.op == swc_pkg::OP_READ)
                            ? r_next.sh : r_reg.rd;
                        r_next.done = 1'b1;
                        r_next.ready = 1'b1;
                        r_next.st = swc_pkg::HS_IDLE;
                    end
                end
            end
            swc_pkg::HS_RST_LOW: begin
                r_next.tmr = r_reg.tmr + 16'h0001;
                if (r_reg.tmr == 16'(RST_LOW_CYC - 1)) begin
                    r_next.oe = 1'b0;
                    r_next.tmr = 16'h0000;
                    r_next.st = swc_pkg::HS_RST_WAIT;
                end
            end
            swc_pkg::HS_RST_WAIT, swc_pkg::HS_SPU: begin
                r_next.tmr = r_reg.tmr + 16'h0001;
                if ((r_reg.st == swc_pkg::HS_SPU &&
                     r_reg.tmr == 16'(SPU_CYC - 1)) ||
                    (r_reg.st == swc_pkg::HS_RST_WAIT &&
                     r_reg.tmr == 16'(RST_WAIT_CYC - 1))) begin
                    r_next.spu = 1'b0;
                    r_next.done = 1'b1;
                    r_next.ready = 1'b1;
                    r_next.st = swc_pkg::HS_IDLE;
                end
            end
            default: begin
                r_next.st = swc_pkg::HS_IDLE;
                r_next.oe = 1'b0;
                r_next.spu = 1'b0;
                r_next.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '{st: swc_pkg::HS_IDLE, dq_s1: 1'b1, dq_s2: 1'b1,
                       oe: 1'b0, spu: 1'b0, ready: 1'b1, done: 1'b0,
                       od: 1'b0, spu_req: 1'b0, op: 2'h0, tmr: 16'h0000,
                       bit_cnt: 3'h0, sh: 8'h00, rd: 8'h00};
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.dq_host_oe = r_reg.oe;
    assign link.spu = r_reg.spu;
    assign op_ready = r_reg.ready;
    assign op_done = r_reg.done;
    assign rd_byte = r_reg.rd;
endmodule : swc_host

// *** swc_assertions.sv ***
// concurrent checks on the host-to-device single-wire link
`timescale 1ns/1ps
module swc_assertions #(
    parameter int RST_LOW_CYC = 600
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic overdrive,
    input wire logic dq_dev_oe,
    input wire logic dq_host_oe,
    input wire logic spu,
    input wire logic dq
);
    localparam int W1 = swc_pkg::OD_W1L_CYC;
    localparam int W0 = swc_pkg::OD_W0L_CYC;
    localparam int DS = swc_pkg::OD_DSMP_CYC;
    // a zero reply ends by the later of the two speeds' sample points
    localparam int ZMAX = swc_pkg::STD_DSMP_CYC + 1;
    // ==========================================================
    // helper counters; the gap counters saturate high in reset so the
    // first slot after reset is not mistaken for a short gap
    logic [15:0] dev_len_reg, host_len_reg, since_reg, high_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dev_len_reg <= 16'h0;
            host_len_reg <= 16'h0;
            since_reg <= 16'hFFFF;
            high_reg <= 16'hFFFF;
        end else begin
            dev_len_reg <= dq_dev_oe ? dev_len_reg + 16'h1 : 16'h0;
            host_len_reg <= dq_host_oe ? host_len_reg + 16'h1 : 16'h0;
            since_reg <= $rose(dq_host_oe) ? 16'h0 :
                since_reg + {15'h0, ~&since_reg};
            high_reg <= dq ? high_reg + {15'h0, ~&high_reg} : 16'h0;
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_zero_hold;
        dq_dev_oe [*8];
    endsequence
    a_reply_in_slot: assert property (
        $rose(dq_dev_oe) |-> dq_host_oe && $past(dq_host_oe, 4))
        else $error("device pulled outside a host slot");
    a_zero_release: assert property (
        $rose(dq_dev_oe) |-> s_zero_hold)
        else $error("device zero reply not held");
    a_zero_bound: assert property (
        dq_dev_oe |-> dev_len_reg <= ZMAX)
        else $error("device zero reply held past its sample point");
    a_zero_length: assert property (
        $fell(dq_dev_oe) && overdrive |-> dev_len_reg inside {[DS-8:DS+1]})
        else $error("device zero reply length off");
    a_release_late: assert property (
        $fell(dq_dev_oe) |-> !dq_host_oe)
        else $error("device released before host");
    a_host_low_len: assert property (
        $fell(dq_host_oe) && overdrive |-> host_len_reg inside
        {[W1-1:W1+1], [W0-1:W0+1], [RST_LOW_CYC-1:RST_LOW_CYC+1]})
        else $error("host low time off");
    a_slot_spacing: assert property (
        $rose(dq_host_oe) && overdrive |->
        since_reg >= swc_pkg::OD_SLOT_CYC)
        else $error("host slot shorter than slot duration");
    a_host_recovery: assert property (
        $rose(dq_host_oe) && overdrive |->
        high_reg >= swc_pkg::OD_REC_CYC - 1)
        else $error("host skipped recovery");
    a_spu_no_pull: assert property (
        spu |-> !dq_host_oe && !dq_dev_oe)
        else $error("line pulled during pull-up bypass");
endmodule : swc_assertions

// *** tb_single_wire_slot_and_chain_discovery.sv ***
// bench joining host and device ends over the single-wire link
`timescale 1ns/1ps
module tb_single_wire_slot_and_chain_discovery;
    localparam logic [63:0] ID_VAL = 64'h5A17C3E29B04D6F1; // arbitrary
    logic core_clk, arst_n, op_valid, spu_after, en_n, gpio, od;
    logic op_ready, op_done, done_oe, en_level;
    logic [1:0] op_code, chain_state;
    logic [7:0] wr_byte, rd_byte;
    logic [63:0] id;
    int err_count, num_checks, cycles;
    integer seed;
    swc_if link ();
    swc_host #(.RST_LOW_CYC(420), .RST_WAIT_CYC(100), .SPU_CYC(50))
    u_swc_host (.core_clk(core_clk), .arst_n(arst_n), .link(link),
        .overdrive(od), .op_valid(op_valid), .op_code(op_code),
        .wr_byte(wr_byte), .spu_after(spu_after), .op_ready(op_ready),
        .op_done(op_done), .rd_byte(rd_byte));
    // reset detect sits between the longest slot low and the reset pulse
    swc_dev #(.ROM_ID(ID_VAL), .RST_DET_CYC(400)) u_swc_dev (
        .core_clk(core_clk), .arst_n(arst_n), .link(link),
        .overdrive(od), .chain_en_n_pin(en_n), .gpio_drive_low(gpio),
        .chain_done_oe(done_oe), .chain_en_level(en_level),
        .chain_state(chain_state));
    swc_assertions #(.RST_LOW_CYC(420)) u_swc_assertions (
        .core_clk(core_clk), .arst_n(arst_n), .overdrive(od),
        .dq_dev_oe(link.dq_dev_oe), .dq_host_oe(link.dq_host_oe),
        .spu(link.spu), .dq(link.dq));
    // ==========================================================
    // tasks
    task automatic check(input string what, input logic [63:0] exp,
        input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic op(input logic [1:0] code, input logic [7:0] b,
        input logic s);
        int n;
        op_code = code;
        wr_byte = b;
        spu_after = s;
        op_valid = 1'b1;
        @(posedge core_clk);
        #1;
        op_valid = 1'b0;
        check("op_ready low", 64'h0, 64'(op_ready));
        for (n = 0; n < 9000 && op_done !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (n == 9000) check("op_done", 64'h1, 64'h0);
        check("op_ready high", 64'h1, 64'(op_ready));
    endtask : op
    task automatic wr(input logic [7:0] b);
        op(swc_pkg::OP_WRITE, b, 1'b0);
    endtask : wr
    // dip shorter than the minimum low; then let the line recover
    task automatic glitch();
        link.noise_low = 1'b1;
        repeat (1 + ($random(seed) & 1)) @(posedge core_clk);
        #1;
        link.noise_low = 1'b0;
        repeat (120) @(posedge core_clk);
        #1;
    endtask : glitch
    task automatic chain(input logic [7:0] ctl, input logic s);
        op(swc_pkg::OP_RESET, 8'h00, 1'b0);
        wr(swc_pkg::CMD_SKIP);
        wr(swc_pkg::CMD_CHAIN);
        wr(ctl);
        op(swc_pkg::OP_WRITE, ~ctl, s);
    endtask : chain
    task automatic cond_read(input int n);
        op(swc_pkg::OP_RESET, 8'h00, 1'b0);
        wr(swc_pkg::CMD_COND_READ);
        for (int i = 0; i < n; i++) begin
            op(swc_pkg::OP_READ, 8'h00, 1'b0);
            id[8*i +: 8] = rd_byte;
        end
    endtask : cond_read
    task automatic gpio_test();
        for (int i = 0; i < 4; i++) begin
            gpio = 1'($random(seed));
            repeat (4) @(posedge core_clk);
            #1;
            check("done pin", 64'(gpio), 64'(done_oe));
        end
    endtask : gpio_test
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // clock, timeout and main sequence
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 100000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        seed = 32'h7eac;
        {arst_n, op_valid, spu_after, en_n, gpio} = 5'h0;
        od = 1'b1;
        link.noise_low = 1'b0;
        op_code = 2'h0;
        wr_byte = 8'h00;
        id = 64'h0;
        repeat (4) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        gpio_test();
        $display("test gpio in chain off done");
        chain(swc_pkg::CTL_ON, 1'b1);
        check("state", 64'(swc_pkg::CH_ON), 64'(chain_state));
        $display("test chain on done");
        en_n = 1'b1;
        cond_read(1);
        check("blocked reply", 64'hFF, id);
        check("enable level", 64'h1, 64'(en_level));
        $display("test enable high done");
        en_n = 1'b0;
        cond_read(8);
        check("identity", ID_VAL, id);
        check("enable level", 64'h0, 64'(en_level));
        glitch();
        wr(swc_pkg::CMD_CHAIN);
        wr(swc_pkg::CTL_DONE);
        wr(~swc_pkg::CTL_DONE);
        check("state", 64'(swc_pkg::CH_DONE), 64'(chain_state));
        check("done pin", 64'h1, 64'(done_oe));
        $display("test discovery done");
        id = 64'h0;
        cond_read(1);
        check("done reply", 64'hFF, id);
        $display("test done device silent");
        chain(swc_pkg::CTL_OFF, 1'b0);
        check("state", 64'(swc_pkg::CH_OFF), 64'(chain_state));
        gpio_test();
        $display("test chain off done");
        print_verdict();
    end
endmodule : tb_single_wire_slot_and_chain_discovery
